// ---- pin_mux_pkg.sv ----
// Constants and register map for the remappable input pin selection block.
package pin_mux_pkg;

  localparam int        SEL_W          = 8;
  localparam int        NUM_PADS       = 16;
  localparam int        NUM_VIRT       = 6;
  localparam int        NUM_PERIPH_IN  = 8;
  localparam int        NUM_DED_OUT    = 4;
  localparam int        NUM_REMAP_OUT  = 4;
  localparam int        ADDR_W         = 8;
  localparam int        DATA_W         = 16;

  // Pin numbering: 0 is ground, pads are 1..NUM_PADS, virtual pins 176..181.
  localparam logic [7:0] PIN_GROUND     = 8'h00;
  localparam logic [7:0] PIN_PAD_FIRST  = 8'h01;
  localparam logic [7:0] PIN_VIRT_FIRST = 8'hb0;
  localparam logic [7:0] PIN_VIRT_LAST  = 8'hb5;

  // Register offsets.
  localparam logic [7:0] OFS_IN_MAP0    = 8'h00;
  localparam logic [7:0] OFS_IN_MAP1    = 8'h01;
  localparam logic [7:0] OFS_IN_MAP2    = 8'h02;
  localparam logic [7:0] OFS_FAULT_SEL  = 8'h03;
  localparam logic [7:0] OFS_DIR        = 8'h10;
  localparam logic [7:0] OFS_ANA_SEL    = 8'h11;
  localparam logic [7:0] OFS_GPIO_OUT   = 8'h12;
  localparam logic [7:0] OFS_DED_EN     = 8'h13;
  localparam logic [7:0] OFS_ANA_EN     = 8'h14;
  localparam logic [7:0] OFS_PAD_IN     = 8'h15;
  localparam logic [7:0] OFS_OUT_MAP0   = 8'h20;
  localparam logic [7:0] OFS_OUT_MAP1   = 8'h21;

  // Reset values.
  localparam logic [15:0] RST_SEL       = 16'h0000;
  localparam logic [15:0] RST_DIR       = 16'hffff;
  localparam logic [15:0] RST_ANA_SEL   = 16'hffff;
  localparam logic [15:0] RST_ZERO      = 16'h0000;

  // Fault selector field positions.
  localparam int        FAULT5_LSB     = 0;
  localparam int        FAULT6_LSB     = 8;
  localparam int        FAULT5_IDX     = 6;
  localparam int        FAULT6_IDX     = 7;

  // Source of a pad's output buffer.
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_GPIO,
    SRC_REMAP,
    SRC_DEDICATED
  } pad_src_t;

endpackage : pin_mux_pkg

// ---- input_selector.sv ----
// One remappable peripheral input: a registered selector lookup.
`timescale 1ns/100ps
module input_selector
  import pin_mux_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic [SEL_W-1:0]      sel,
  input  wire logic [NUM_PADS-1:0]   pad_in,
  input  wire logic [NUM_VIRT-1:0]   virt_in,
  output logic                       periph_in_r
);

  logic periph_in_nxt;

  // Codes that name no pin read as ground.
  always_comb begin
    periph_in_nxt = 1'b0;
    if (sel >= PIN_PAD_FIRST && sel < PIN_PAD_FIRST + 8'(NUM_PADS)) begin
      periph_in_nxt = pad_in[4'(sel - PIN_PAD_FIRST)];
    end else if (sel >= PIN_VIRT_FIRST && sel <= PIN_VIRT_LAST) begin
      periph_in_nxt = virt_in[3'(sel - PIN_VIRT_FIRST)];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      periph_in_r <= 1'b0;
    end else begin
      periph_in_r <= periph_in_nxt;
    end
  end

endmodule : input_selector

// ---- pad_sync.sv ----
// Three-stage synchroniser for pad inputs; a change is accepted when stages two and three agree.
`timescale 1ns/100ps
module pad_sync
  import pin_mux_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic [NUM_PADS-1:0]   d,
  output logic [NUM_PADS-1:0]        q_r
);

  logic [NUM_PADS-1:0] s1_r;
  logic [NUM_PADS-1:0] s2_r;
  logic [NUM_PADS-1:0] s3_r;
  logic [NUM_PADS-1:0] s1_nxt;
  logic [NUM_PADS-1:0] s2_nxt;
  logic [NUM_PADS-1:0] s3_nxt;
  logic [NUM_PADS-1:0] q_nxt;

  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    q_nxt  = q_r;
    for (int i = 0; i < NUM_PADS; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      q_r  <= q_nxt;
    end
  end

endmodule : pad_sync

// ---- remap_input_mux.sv ----
// Remappable pin selection fabric: input mapping, virtual pins and pad output priority.
//
// Contract
// - Eight-bit selector per remappable peripheral input.
// - Out-of-range selector codes name no pin.
// - Six virtual pins numbered 176 to 181.
// - Output on virtual pin feeds other inputs.
// - At most one output drives a pin.
// - One remappable output may drive many pins.
// - Dedicated output beats remappable output.
// - Many inputs may share one pin.
// - Analog function disables pin digital inputs.
// - Direction gates only general-purpose output.
// - Reset leaves pins analog, input buffer off.
// - Only analog select gates input buffer.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
module remap_input_mux
  import pin_mux_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         arst_n,
  input  wire logic [ADDR_W-1:0]            reg_addr,
  input  wire logic [DATA_W-1:0]            reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [DATA_W-1:0]                 reg_rdata_r,
  input  wire logic [NUM_PADS-1:0]          pad_in,
  output logic [NUM_PADS-1:0]               pad_out_r,
  output logic [NUM_PADS-1:0]               pad_oe_n_r,
  input  wire logic [NUM_DED_OUT-1:0]       ded_out,
  input  wire logic [NUM_REMAP_OUT-1:0]     remap_out,
  output logic [NUM_PERIPH_IN-1:0]          periph_in_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [DATA_W-1:0] in_map_r [4];
  logic [DATA_W-1:0] in_map_nxt [4];
  logic [DATA_W-1:0] dir_r;
  logic [DATA_W-1:0] dir_nxt;
  logic [DATA_W-1:0] ana_sel_r;
  logic [DATA_W-1:0] ana_sel_nxt;
  logic [DATA_W-1:0] gpio_out_r;
  logic [DATA_W-1:0] gpio_out_nxt;
  logic [DATA_W-1:0] ded_en_r;
  logic [DATA_W-1:0] ded_en_nxt;
  logic [DATA_W-1:0] ana_en_r;
  logic [DATA_W-1:0] ana_en_nxt;
  logic [DATA_W-1:0] out_map_r [2];
  logic [DATA_W-1:0] out_map_nxt [2];
  logic [DATA_W-1:0] rdata_nxt;
  logic [NUM_PADS-1:0] pad_sync_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      in_map_nxt[i] = in_map_r[i];
    end
    out_map_nxt[0] = out_map_r[0];
    out_map_nxt[1] = out_map_r[1];
    dir_nxt        = dir_r;
    ana_sel_nxt    = ana_sel_r;
    gpio_out_nxt   = gpio_out_r;
    ded_en_nxt     = ded_en_r;
    ana_en_nxt     = ana_en_r;
    if (reg_wr) begin
      case (reg_addr)
        OFS_IN_MAP0:   in_map_nxt[0]  = reg_wdata;
        OFS_IN_MAP1:   in_map_nxt[1]  = reg_wdata;
        OFS_IN_MAP2:   in_map_nxt[2]  = reg_wdata;
        OFS_FAULT_SEL: in_map_nxt[3]  = reg_wdata;
        OFS_DIR:       dir_nxt        = reg_wdata;
        OFS_ANA_SEL:   ana_sel_nxt    = reg_wdata;
        OFS_GPIO_OUT:  gpio_out_nxt   = reg_wdata;
        OFS_DED_EN:    ded_en_nxt     = reg_wdata;
        OFS_ANA_EN:    ana_en_nxt     = reg_wdata;
        OFS_OUT_MAP0:  out_map_nxt[0] = reg_wdata;
        OFS_OUT_MAP1:  out_map_nxt[1] = reg_wdata;
        default:       ;
      endcase
    end
  end

  // Unmapped addresses read as zero.
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_IN_MAP0:   rdata_nxt = in_map_r[0];
        OFS_IN_MAP1:   rdata_nxt = in_map_r[1];
        OFS_IN_MAP2:   rdata_nxt = in_map_r[2];
        OFS_FAULT_SEL: rdata_nxt = in_map_r[3];
        OFS_DIR:       rdata_nxt = dir_r;
        OFS_ANA_SEL:   rdata_nxt = ana_sel_r;
        OFS_GPIO_OUT:  rdata_nxt = gpio_out_r;
        OFS_DED_EN:    rdata_nxt = ded_en_r;
        OFS_ANA_EN:    rdata_nxt = ana_en_r;
        OFS_PAD_IN:    rdata_nxt = pad_sync_r & ~ana_sel_r;
        OFS_OUT_MAP0:  rdata_nxt = out_map_r[0];
        OFS_OUT_MAP1:  rdata_nxt = out_map_r[1];
        default:       rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        in_map_r[i] <= RST_SEL;
      end
      out_map_r[0] <= RST_ZERO;
      out_map_r[1] <= RST_ZERO;
      dir_r        <= RST_DIR;
      ana_sel_r    <= RST_ANA_SEL;
      gpio_out_r   <= RST_ZERO;
      ded_en_r     <= RST_ZERO;
      ana_en_r     <= RST_ZERO;
      reg_rdata_r  <= RST_ZERO;
    end else begin
      for (int i = 0; i < 4; i++) begin
        in_map_r[i] <= in_map_nxt[i];
      end
      out_map_r[0] <= out_map_nxt[0];
      out_map_r[1] <= out_map_nxt[1];
      dir_r        <= dir_nxt;
      ana_sel_r    <= ana_sel_nxt;
      gpio_out_r   <= gpio_out_nxt;
      ded_en_r     <= ded_en_nxt;
      ana_en_r     <= ana_en_nxt;
      reg_rdata_r  <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad outputs. Each pad has a 2-bit remap field picking one remappable
  // output, a zero field leaving the pad unmapped; several pads may name
  // the same source, which is how outputs get paralleled for drive strength.

  pad_src_t          src      [NUM_PADS];
  logic [NUM_PADS-1:0] out_nxt;
  logic [NUM_PADS-1:0] oe_n_nxt;
  logic [NUM_PADS-1:0] remap_en;
  logic [1:0]        remap_idx [NUM_PADS];

  always_comb begin
    for (int p = 0; p < NUM_PADS; p++) begin
      remap_idx[p] = out_map_r[p / 8][(p % 8) * 2 +: 2];
      remap_en[p]  = (remap_idx[p] != 2'h0);
      // A single priority chain gives every pad at most one driver.
      if (ded_en_r[p]) begin
        src[p] = SRC_DEDICATED;
      end else if (remap_en[p]) begin
        src[p] = SRC_REMAP;
      end else if (!dir_r[p]) begin
        src[p] = SRC_GPIO;
      end else begin
        src[p] = SRC_NONE;
      end
    end
  end

  always_comb begin
    out_nxt  = '0;
    oe_n_nxt = '1;
    for (int p = 0; p < NUM_PADS; p++) begin
      case (src[p])
        SRC_DEDICATED: begin
          out_nxt[p]  = ded_out[p % NUM_DED_OUT];
          oe_n_nxt[p] = 1'b0;
        end
        SRC_REMAP: begin
          out_nxt[p]  = remap_out[remap_idx[p]];
          oe_n_nxt[p] = 1'b0;
        end
        SRC_GPIO: begin
          out_nxt[p]  = gpio_out_r[p];
          oe_n_nxt[p] = 1'b0;
        end
        default: begin
          out_nxt[p]  = 1'b0;
          oe_n_nxt[p] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pad_out_r  <= '0;
      pad_oe_n_r <= '1;
    end else begin
      pad_out_r  <= out_nxt;
      pad_oe_n_r <= oe_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad input path and virtual pins.

  logic [NUM_PADS-1:0] pad_dig;
  logic [NUM_VIRT-1:0] virt;
  logic [SEL_W-1:0]    sel [NUM_PERIPH_IN];

  pad_sync i_pad_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (pad_in),
    .q_r    (pad_sync_r)
  );

  // Direction is not consulted: the input buffer depends on analog select only,
  // and an analog function on the pad also kills it.
  always_comb begin
    pad_dig = pad_sync_r & ~ana_sel_r & ~ana_en_r;
    // Remappable outputs wrap round the six virtual pins.
    for (int v = 0; v < NUM_VIRT; v++) begin
      virt[v] = remap_out[v % NUM_REMAP_OUT];
    end
    for (int k = 0; k < NUM_PERIPH_IN; k++) begin
      sel[k] = in_map_r[k / 2][(k % 2) * SEL_W +: SEL_W];
    end
  end

  for (genvar k = 0; k < NUM_PERIPH_IN; k++) begin : g_in
    input_selector i_input_selector (
      .mclk        (mclk),
      .arst_n      (arst_n),
      .sel         (sel[k]),
      .pad_in      (pad_dig),
      .virt_in     (virt),
      .periph_in_r (periph_in_r[k])
    );
  end

endmodule : remap_input_mux

// ---- remap_input_mux_sva.sv ----
// Assertion checker for the remappable input pin selection block.
`timescale 1ns/100ps
module remap_input_mux_sva
  import pin_mux_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_r,
  input wire logic [15:0] pad_out_r,
  input wire logic [15:0] pad_oe_n_r,
  input wire logic [3:0]  ded_out,
  input wire logic [3:0]  remap_out,
  input wire logic [7:0]  periph_in_r
);
  ////////////////////////////////////////
  // Quiet counts edges since the last write, so that checks skip the update latency.
  logic [15:0] fsel_sh, ded_sh, ans_sh, aen_sh;
  logic [1:0]  quiet;
  logic [3:0]  pidx;
  assign pidx = fsel_sh[3:0] - 4'h1;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fsel_sh <= RST_SEL;
      ded_sh  <= RST_ZERO;
      ans_sh  <= RST_ANA_SEL;
      aen_sh  <= RST_ZERO;
      quiet   <= 2'h0;
    end else begin
      quiet <= reg_wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      if (reg_wr && reg_addr == OFS_FAULT_SEL) fsel_sh <= reg_wdata;
      if (reg_wr && reg_addr == OFS_DED_EN) ded_sh <= reg_wdata;
      if (reg_wr && reg_addr == OFS_ANA_SEL) ans_sh <= reg_wdata;
      if (reg_wr && reg_addr == OFS_ANA_EN) aen_sh <= reg_wdata;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_rdata_slot: assert property (reg_rdata_r != 16'h0 |-> $past(reg_rd))
    else $error("read data outside its slot");
  a_reset_state: assert property (!$past(arst_n) |-> pad_oe_n_r == 16'hffff && periph_in_r == 8'h0)
    else $error("state after reset wrong");
  a_ded_drive: assert property (quiet == 2'h3 |-> ((pad_out_r ^ {4{$past(ded_out)}}) & ded_sh) == 16'h0)
    else $error("dedicated output not on pad");
  a_ded_oe: assert property (quiet == 2'h3 |-> (pad_oe_n_r & ded_sh) == 16'h0)
    else $error("dedicated pad not driven");
  a_virt_feed: assert property (quiet == 2'h3 && fsel_sh[7:0] inside {[8'hb0:8'hb5]}
    |-> periph_in_r[6] == $past(remap_out[fsel_sh[1:0]]))
    else $error("virtual pin not routed");
  a_fault_ground: assert property (quiet == 2'h3 && !(fsel_sh[15:8] inside {[8'h01:8'h10], [8'hb0:8'hb5]})
    |-> !periph_in_r[7])
    else $error("invalid code not grounded");
  a_analog_block: assert property (quiet == 2'h3 && fsel_sh[7:0] inside {[8'h01:8'h10]}
    && (ans_sh[pidx] || aen_sh[pidx]) |-> !periph_in_r[6])
    else $error("analog pad reached digital input");
  a_share_pin: assert property (quiet == 2'h3 && fsel_sh[7:0] == fsel_sh[15:8]
    |-> periph_in_r[6] == periph_in_r[7])
    else $error("shared pin seen differently");
endmodule : remap_input_mux_sva

// ---- periph_model.sv ----
// Far side: peripheral outputs and the external drivers of the pads.
`timescale 1ns/100ps
module periph_model (
  input  wire logic [15:0] pad_out_r,
  input  wire logic [15:0] pad_oe_n_r,
  input  wire logic [15:0] ext_drv,
  input  wire logic [15:0] ext_lvl,
  input  wire logic [15:0] wander,
  output logic      [15:0] pad_in
);
  // A pad nobody drives has no pull, so it wanders instead of keeping its last level.
  assign pad_in = (~pad_oe_n_r & pad_out_r) | (pad_oe_n_r & ((ext_drv & ext_lvl) | (~ext_drv & wander)));
endmodule : periph_model

// ---- remap_input_mux_tb_top.sv ----
// Self-checking testbench for the remappable input pin selection block.
`timescale 1ns/100ps
module remap_input_mux_tb_top;
  import pin_mux_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0, reg_rdata_r, v, g;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] pad_in, pad_out_r, pad_oe_n_r, ext_drv = 16'h0, ext_lvl = 16'h0, wander = 16'h5555;
  logic [3:0]  ded_out = 4'h0, remap_out = 4'h0;
  logic [7:0]  periph_in_r;
  logic [7:0]  ofs [8] = '{OFS_FAULT_SEL, OFS_DIR, OFS_ANA_SEL, OFS_DED_EN, OFS_IN_MAP0, OFS_OUT_MAP0, 8'h7f, OFS_PAD_IN};
  logic [15:0] rst [8] = '{16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [7:0]  codes [12] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'h00, 8'h11, 8'hb6, 8'hff, 8'h01, 8'h10};
  int fails = 0;
  int n_compared = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) wander <= ~wander;
  remap_input_mux i_remap_input_mux (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .pad_in(pad_in), .pad_out_r(pad_out_r),
    .pad_oe_n_r(pad_oe_n_r), .ded_out(ded_out), .remap_out(remap_out), .periph_in_r(periph_in_r));
  periph_model i_periph_model (.pad_out_r(pad_out_r), .pad_oe_n_r(pad_oe_n_r), .ext_drv(ext_drv),
    .ext_lvl(ext_lvl), .wander(wander), .pad_in(pad_in));
  ////////////////////////////////////////
  function automatic logic sel_exp(input logic [7:0] c, input logic [15:0] pads, input logic [3:0] rmp);
    if (c inside {[8'h01:8'h10]}) return pads[c - 8'h01];
    if (c inside {[8'hb0:8'hb5]}) return rmp[c[1:0]];
    return 1'b0;
  endfunction : sel_exp
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask : rd
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle
  task automatic end_of_test();
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(55));
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i], v);
      chk(v, rst[i]);
    end
    $display("test reset_values done");
    g = 16'($urandom);
    wr(OFS_FAULT_SEL, g);
    wr(8'h7f, 16'hffff);
    rd(OFS_FAULT_SEL, v);
    chk(v, g);
    rd(8'h7f, v);
    chk(v, 16'h0);
    $display("test readback done");
    // Externally driven pads stay inputs, since a remapped input never turns the output buffer on.
    wr(OFS_ANA_SEL, 16'h0);
    ext_drv <= 16'hffff;
    foreach (codes[i]) begin
      for (int j = 0; j < 4; j++) begin
        wr(OFS_IN_MAP0 + 8'(j), {codes[i], codes[i]});
      end
      ext_lvl <= 16'($urandom);
      remap_out <= 4'($urandom);
      settle();
      chk({8'h0, periph_in_r}, {8'h0, {8{sel_exp(codes[i], ext_lvl, remap_out)}}});
    end
    $display("test selector_codes done");
    wr(OFS_FAULT_SEL, 16'h0303);
    ext_lvl <= 16'hffff;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_ANA_SEL, i == 0 ? 16'h0004 : 16'h0);
      wr(OFS_ANA_EN, i == 1 ? 16'h0004 : 16'h0);
      settle();
      chk({14'h0, periph_in_r[7:6]}, i == 2 ? 16'h0003 : 16'h0);
      rd(OFS_PAD_IN, v);
      chk(v, i == 0 ? 16'hfffb : 16'hffff);
    end
    $display("test analog_gating done");
    g = 16'($urandom);
    wr(OFS_GPIO_OUT, g);
    ext_drv <= 16'h0;
    wr(OFS_DIR, 16'hff00);
    settle();
    chk(pad_oe_n_r, 16'hff00);
    chk(pad_out_r & 16'h00ff, g & 16'h00ff);
    wr(OFS_DIR, 16'hffff);
    remap_out <= 4'($urandom);
    wr(OFS_OUT_MAP0, 16'h5555);
    settle();
    chk(pad_oe_n_r, 16'hff00);
    chk(pad_out_r & 16'h00ff, {8'h00, {8{remap_out[1]}}});
    wr(OFS_DED_EN, 16'h000f);
    ded_out <= 4'($urandom);
    wr(OFS_IN_MAP0, 16'h0202);
    wr(OFS_FAULT_SEL, 16'h0202);
    settle();
    chk(pad_out_r & 16'h00ff, {8'h00, {4{remap_out[1]}}, ded_out});
    chk({12'h0, periph_in_r[7:6], periph_in_r[1:0]}, {12'h0, {4{ded_out[1]}}});
    wr(OFS_ANA_EN, 16'hffff);
    settle();
    chk(pad_oe_n_r, 16'hff00);
    chk({14'h0, periph_in_r[7:6]}, 16'h0);
    wr(OFS_OUT_MAP1, 16'he4e4);
    settle();
    chk(pad_oe_n_r, 16'h1100);
    chk(pad_out_r & 16'hff00, {{2{remap_out[3:1], 1'b0}}, 8'h00});
    $display("test output_priority done");
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd(OFS_ANA_SEL, v);
    chk(v, RST_ANA_SEL);
    chk(pad_oe_n_r, 16'hffff);
    $display("test second_reset done");
    end_of_test();
  end
endmodule : remap_input_mux_tb_top

bind remap_input_mux remap_input_mux_sva i_remap_input_mux_sva (.mclk(mclk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .pad_out_r(pad_out_r), .pad_oe_n_r(pad_oe_n_r), .ded_out(ded_out), .remap_out(remap_out),
  .periph_in_r(periph_in_r));
